/* File: hdl/port_link_status_register.sv */
// port-two link status register with change interrupt
// assumes transceiver status inputs synchronous to core_clk, strobes one cycle each
`timescale 1ns/1ps
module port_link_status_register (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // register port
  input wire logic [port_status_pkg::addr_w-1:0] reg_addr,
  input wire logic [port_status_pkg::data_w-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [port_status_pkg::data_w-1:0] reg_rdata,
  // transceiver status
  input wire logic phy_polarity_reversed,
  input wire logic rx_flow_ctrl_active,
  input wire logic tx_flow_ctrl_active,
  input wire logic phy_speed_100,
  input wire logic phy_full_duplex,
  input wire logic phy_mdi,
  input wire logic phy_an_done,
  input wire logic phy_link_good,
  input wire logic [4:0] partner_ability,
  // crossover select mirror toward the transceiver
  output logic crossover_algorithm_select,
  // interrupt
  output logic irq
);
  logic [15:0] raw_status;
  logic [15:0] live_status;
  logic [15:0] prev_status;
  logic [15:0] irq_status;
  logic [15:0] irq_mask;
  logic [15:0] next_irq_status;
  logic [15:0] next_rdata;
  logic [15:0] change;
  logic primed;
  wire hit_status = (reg_addr == port_status_pkg::port_two_link_status_off);
  wire hit_irq_status = (reg_addr == port_status_pkg::irq_status_off);
  wire hit_irq_mask = (reg_addr == port_status_pkg::irq_mask_off);
  wire wr_status = reg_wr && hit_status;
  wire wr_irq_status = reg_wr && hit_irq_status;
  wire wr_irq_mask = reg_wr && hit_irq_mask;

  assign raw_status[port_status_pkg::bit_xover_sel] = 1'b0;
  assign raw_status[14] = 1'b0;
  assign raw_status[port_status_pkg::bit_polarity] = phy_polarity_reversed;
  assign raw_status[port_status_pkg::bit_rx_fc] = rx_flow_ctrl_active;
  assign raw_status[port_status_pkg::bit_tx_fc] = tx_flow_ctrl_active;
  assign raw_status[port_status_pkg::bit_speed] = phy_speed_100;
  assign raw_status[port_status_pkg::bit_duplex] = phy_full_duplex;
  assign raw_status[8] = 1'b0;
  assign raw_status[port_status_pkg::bit_mdi] = phy_mdi;
  assign raw_status[port_status_pkg::bit_an_done] = phy_an_done;
  assign raw_status[port_status_pkg::bit_link_good] = phy_link_good;
  // partner ability order: pause, 100fd, 100hd, 10fd, 10hd
  assign raw_status[port_status_pkg::bit_lp_pause:port_status_pkg::bit_lp_10hd] =
    partner_ability;

  sync_capture #(
    .width(16)
  ) u_capture (
    .core_clk(core_clk),
    .resetn(resetn),
    .din(raw_status & port_status_pkg::live_mask),
    .dout(live_status)
  );

  // the stored bit itself drives the transceiver, so the mirror can never disagree
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      crossover_algorithm_select <= port_status_pkg::xover_sel_reset[15];
    else if (wr_status)
      crossover_algorithm_select <= reg_wdata[port_status_pkg::bit_xover_sel];
  end

  // change detection starts one cycle after reset so reset values raise nothing
  assign change = primed ? (live_status ^ prev_status) : 16'h0000;
  // set wins over a write-one clear in the same cycle
  assign next_irq_status = (irq_status & ~(wr_irq_status ? reg_wdata : 16'h0000)) | change;

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      prev_status <= port_status_pkg::status_reset;
      primed <= 1'b0;
      irq_status <= 16'h0000;
    end
    else
    begin
      prev_status <= live_status;
      primed <= 1'b1;
      irq_status <= next_irq_status & port_status_pkg::live_mask;
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      irq_mask <= 16'h0000;
    else if (wr_irq_mask)
      irq_mask <= reg_wdata & port_status_pkg::live_mask;
  end

  assign irq = |(irq_status & irq_mask);

  // read-only bits ignore writes; unmapped addresses read zero
  assign next_rdata = hit_status ?
    ({crossover_algorithm_select, 15'h0000} | live_status) :
    hit_irq_status ? irq_status :
    hit_irq_mask ? irq_mask : 16'h0000;

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      reg_rdata <= 16'h0000;
    else if (reg_rd)
      reg_rdata <= next_rdata;
    else
      reg_rdata <= 16'h0000;
  end
endmodule : port_link_status_register

/* File: hdl/port_status_pkg.sv */
// constants and layout of the port-two link status register block
// assumes a plain strobe register port with read data one cycle after the read strobe
package port_status_pkg;
  localparam int addr_w = 8;
  localparam int data_w = 16;
  localparam logic [7:0] port_two_link_status_off = 8'h04;
  localparam logic [7:0] irq_status_off = 8'h08;
  localparam logic [7:0] irq_mask_off = 8'h0c;
  localparam int bit_xover_sel = 15;
  localparam int bit_polarity = 13;
  localparam int bit_rx_fc = 12;
  localparam int bit_tx_fc = 11;
  localparam int bit_speed = 10;
  localparam int bit_duplex = 9;
  localparam int bit_mdi = 7;
  localparam int bit_an_done = 6;
  localparam int bit_link_good = 5;
  localparam int bit_lp_pause = 4;
  localparam int bit_lp_100fd = 3;
  localparam int bit_lp_100hd = 2;
  localparam int bit_lp_10fd = 1;
  localparam int bit_lp_10hd = 0;
  localparam logic [15:0] xover_sel_reset = 16'h8000;
  localparam logic [15:0] status_reset = 16'h0000;
  // bits 14 and 8 are reserved and never set
  localparam logic [15:0] live_mask = 16'h3eff;
endpackage : port_status_pkg

/* File: hdl/sync_capture.sv */
// one flop stage per live status bit, registered so reads see a stable word
// assumes inputs are synchronous to core_clk
`timescale 1ns/1ps
module sync_capture #(
  parameter int width = 16
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // data
  input wire logic [width-1:0] din,
  output logic [width-1:0] dout
);
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      dout <= '0;
    else
      dout <= din;
  end
endmodule : sync_capture

/* File: verif/link_partner_model.sv */
// link partner model: drives the transceiver status levels
// assumes cfg holds the wanted word in status bit positions
`timescale 1ns/1ps
module link_partner_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // wanted link state and the levels shown to the block
  input wire logic [15:0] cfg,
  output logic [15:0] st
);
  // one cycle to settle, as a transceiver resolving a new link state
  always_ff @(posedge core_clk or negedge resetn) st <= !resetn ? 16'h0000 : cfg;
endmodule : link_partner_model

/* File: verif/link_status_sva.sv */
// checker for the link status register ports
// assumes it is bound onto port_link_status_register
`timescale 1ns/1ps
module link_status_sva (
  input wire logic core_clk, resetn, reg_wr, reg_rd, crossover_algorithm_select,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata, reg_rdata,
  input wire logic phy_polarity_reversed,
  input wire logic [4:0] partner_ability
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  wire logic rd4 = reg_rd && reg_addr == 8'h04, wr4 = reg_wr && reg_addr == 8'h04;
  wire logic sel = crossover_algorithm_select, pol = phy_polarity_reversed;
  chk_rsv_zero: assert property (!(reg_rdata[14] | reg_rdata[8])) else $error("rsv");
  chk_sel_write: assert property (wr4 |=> sel == $past(reg_wdata[15])) else $error("wr");
  chk_sel_hold: assert property (!wr4 |=> $stable(sel)) else $error("sel");
  chk_sel_read: assert property (rd4 |=> reg_rdata[15] == $past(sel)) else $error("b15");
  chk_pol_read: assert property (rd4 |=> reg_rdata[13] == $past(pol, 2)) else $error("b13");
  chk_pa_read: assert property (rd4 |=> reg_rdata[4:0] == $past(partner_ability, 2))
    else $error("pa");
  chk_idle_zero: assert property (!reg_rd |=> reg_rdata == 16'h0000) else $error("idle");
  chk_hole_zero: assert property (reg_rd && reg_addr > 8'h0c |=> !reg_rdata)
    else $error("hole");
endmodule : link_status_sva
bind port_link_status_register link_status_sva u_link_status_sva (.core_clk, .resetn, .reg_wr,
  .reg_rd, .crossover_algorithm_select, .reg_addr, .reg_wdata, .reg_rdata,
  .phy_polarity_reversed, .partner_ability);

/* File: verif/testbench.sv */
// self-checking bench for the port-two link status register
// assumes link_partner_model stands in for the transceiver
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module testbench;
  logic core_clk = 1'h0, resetn = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, irq, sel;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000, cfg = 16'h0000, st, reg_rdata;
  int miscompares = 0, num_checks = 0, cyc = 0;
  link_partner_model u_link_partner_model (.core_clk, .resetn, .cfg, .st);
  port_link_status_register u_port_link_status_register (.core_clk, .resetn, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .phy_polarity_reversed(st[13]), .irq,
    .rx_flow_ctrl_active(st[12]), .tx_flow_ctrl_active(st[11]), .phy_speed_100(st[10]),
    .phy_full_duplex(st[9]), .phy_mdi(st[7]), .phy_an_done(st[6]), .phy_link_good(st[5]),
    .partner_ability(st[4:0]), .crossover_algorithm_select(sel));
  initial forever #50 core_clk = ~core_clk;
  task end_sim(input int t);
    miscompares += t;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  // ceiling is far above the roughly 140 cycles the run needs
  always @(posedge core_clk) if (++cyc == 3000) end_sim(1);
  // one write, or one read whose data d is the expected word
  task acc(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'h0;
    reg_rd <= 1'h0;
    #1 if (!w) `CHK("reg_rdata", d, reg_rdata)
  endtask : acc
  task t_regs;
    acc(1'h0, 8'h04, 16'h8000);
    acc(1'h1, 8'h04, 16'h7fff);
    acc(1'h0, 8'h04, 16'h0000);
    acc(1'h1, 8'h04, 16'hffff);
    acc(1'h0, 8'h10, 16'h0000);
    `CHK("sel", 1'h1, sel)
    $display("regs test done");
  endtask : t_regs
  // walking one over the live word; only the link-good change is unmasked
  task t_live;
    acc(1'h1, 8'h0c, 16'h0020);
    for (int i = 0; i < 16; i++)
    begin
      @(posedge core_clk) cfg <= 16'h0001 << i;
      repeat (4) @(posedge core_clk);
      acc(1'h0, 8'h04, 16'h8000 | 16'h3eff & cfg);
      `CHK("irq", i > 4, irq)
    end
    // every live bit rose and fell once, so all live change flags are sticky now
    acc(1'h0, 8'h08, 16'h3eff);
    acc(1'h0, 8'h0c, 16'h0020);
    acc(1'h1, 8'h08, 16'hffff);
    acc(1'h0, 8'h08, 16'h0000);
    `CHK("irq", 1'h0, irq)
    $display("live test done");
  endtask : t_live
  initial
  begin
    repeat (8) @(posedge core_clk);
    resetn <= 1'h1;
    t_regs();
    t_live();
    end_sim(0);
  end
endmodule : testbench
